// ### rtl/gwec_wake_counter.v
// gwec_wake_counter.v: gpio wake event counter with apb register slave
// assumes: pins synchronous to clk_in, 125 MHz clock, synchronous active-high reset
// Function
// R1: per-pin select makes pin an event source
// R2: all pins selected, any pin can wake
// R3: per-pin polarity picks active edge
// R4: polarity 0: rising edge raises key hit
// R5: polarity 1: falling edge raises key hit
// R6: active edge loads debounce, decrement per millisecond
// R7: count only if key hit at zero
// R8: debounce spans 0 to 63 ms
// R9: wait opposite edge before idle again
// R10: threshold match clears counter, raises irq
// R11: any write to irq clear clears irq; here a threshold match with irq enable in the same cycle keeps wake_irq set
// R12: any write to counter clear zeroes counter; here a same-cycle counted event below threshold steps it instead
// R13: counter readable anytime without disturbing counting
// R14: wake chip after programmed event count; here wake_out follows wake_irq, so it rises only with the irq enable bit set
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "gwec_consts.vh"

module gwec_wake_counter (
	input wire clk_in,
	input wire sys_rst_in,
	input wire clk_en_in,
	input wire [`GWEC_PINS-1:0] gpio_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [11:0] paddr_in,
	input wire [31:0] pwdata_in,
	output wire pready_out,
	output wire pslverr_out,
	output reg [31:0] prdata_out,
	output wire irq_out,
	output wire wake_out
);
	localparam ST_IDLE = 2'd0;
	localparam ST_DEB = 2'd1;
	localparam ST_WAIT_REL = 2'd2;
	localparam TICK_W = 17;
	// last prescaler count, compared through a part-select so widths match on purpose
	localparam integer TICK_LAST = `GWEC_TICK_CYC - 1;

	reg [6:0] wake_control;
	reg [`GWEC_PINS-1:0] wake_source_select;
	reg [`GWEC_PINS-1:0] wake_edge_polarity;
	reg [`GWEC_CNT_W-1:0] event_count_threshold;
	reg [`GWEC_CNT_W-1:0] event_count_value;
	reg [1:0] irq_status;
	reg [1:0] irq_mask;
	reg wake_irq;
	reg [`GWEC_PINS-1:0] gpio_prev;
	reg [1:0] state;
	reg [5:0] deb_cnt;
	reg [TICK_W-1:0] tick_cnt;
	reg [31:0] next_rdata;

	function addr_hit;
		input [11:0] a;
		input [11:0] off;
		begin
			addr_hit = (a == off);
		end
	endfunction

	wire access = psel_in & penable_in;
	wire wr = access & pwrite_in;
	wire known = addr_hit(paddr_in, `GWEC_OFF_CTRL) | addr_hit(paddr_in, `GWEC_OFF_SEL) |
		addr_hit(paddr_in, `GWEC_OFF_POL) | addr_hit(paddr_in, `GWEC_OFF_THR) |
		addr_hit(paddr_in, `GWEC_OFF_IRQ_CLR) | addr_hit(paddr_in, `GWEC_OFF_CNT_CLR) |
		addr_hit(paddr_in, `GWEC_OFF_CNT) | addr_hit(paddr_in, `GWEC_OFF_STAT) |
		addr_hit(paddr_in, `GWEC_OFF_MASK);
	// zero wait states, single cycle access phase
	assign pready_out = 1'b1;
	assign pslverr_out = access & ~known;

	// active level per pin: polarity inverts the raw pin
	wire [`GWEC_PINS-1:0] act_now = gpio_in ^ wake_edge_polarity; // R3
	wire [`GWEC_PINS-1:0] act_prev = gpio_prev ^ wake_edge_polarity;
	// rising edge of the active level covers both polarities
	wire [`GWEC_PINS-1:0] act_edge = act_now & ~act_prev & wake_source_select; // R1 R4 R5
	wire any_edge = |act_edge; // R2
	// key hit: some selected pin sits at its active level
	wire key_hit = |(act_now & wake_source_select);
	wire tick = (tick_cnt == TICK_LAST[TICK_W-1:0]);
	wire [5:0] deb_reload = wake_control[`GWEC_CTRL_DEB_MSB:`GWEC_CTRL_DEB_LSB]; // R8
	wire count_ok = (state == ST_DEB) && (deb_cnt == 6'h00) && key_hit; // R7
	wire [`GWEC_CNT_W-1:0] inc_val = event_count_value + 8'h01;
	wire match = count_ok && (inc_val == event_count_threshold); // R10
	wire irq_clr_wr = wr & addr_hit(paddr_in, `GWEC_OFF_IRQ_CLR);
	wire cnt_clr_wr = wr & addr_hit(paddr_in, `GWEC_OFF_CNT_CLR);

	assign irq_out = |(irq_status & irq_mask);
	assign wake_out = wake_irq; // R14

	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			tick_cnt <= {TICK_W{1'b0}};
			gpio_prev <= {`GWEC_PINS{1'b0}};
		end else if (clk_en_in) begin
			// free-running millisecond prescaler
			tick_cnt <= tick ? {TICK_W{1'b0}} : tick_cnt + 17'd1; // R6
			gpio_prev <= gpio_in;
		end
	end

	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			state <= ST_IDLE;
			deb_cnt <= 6'h00;
		end else if (clk_en_in) begin
			case (state)
			ST_IDLE: begin
				if (any_edge) begin
					deb_cnt <= deb_reload; // R6
					state <= ST_DEB;
				end
			end
			ST_DEB: begin
				if (deb_cnt == 6'h00) begin
					// bounce back to idle: edge dropped, not counted
					state <= key_hit ? ST_WAIT_REL : ST_IDLE; // R7
				end else if (tick) begin
					deb_cnt <= deb_cnt - 6'h01; // R6
				end
			end
			ST_WAIT_REL: begin
				if (!key_hit)
					state <= ST_IDLE; // R9
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			wake_control <= `GWEC_CTRL_RST;
			wake_source_select <= `GWEC_SEL_RST;
			wake_edge_polarity <= `GWEC_POL_RST;
			event_count_threshold <= `GWEC_THR_RST;
			irq_mask <= `GWEC_MASK_RST;
			event_count_value <= {`GWEC_CNT_W{1'b0}};
			wake_irq <= 1'b0;
			irq_status <= 2'h0;
		end else if (clk_en_in) begin
			if (wr && addr_hit(paddr_in, `GWEC_OFF_CTRL))
				wake_control <= pwdata_in[6:0];
			if (wr && addr_hit(paddr_in, `GWEC_OFF_SEL))
				wake_source_select <= pwdata_in[`GWEC_PINS-1:0];
			if (wr && addr_hit(paddr_in, `GWEC_OFF_POL))
				wake_edge_polarity <= pwdata_in[`GWEC_PINS-1:0];
			if (wr && addr_hit(paddr_in, `GWEC_OFF_THR))
				event_count_threshold <= pwdata_in[`GWEC_CNT_W-1:0];
			if (wr && addr_hit(paddr_in, `GWEC_OFF_MASK))
				irq_mask <= pwdata_in[1:0];
			// a counted event in the clear cycle wins: the count steps, or zeroes on a match, and the clear is dropped
			if (match)
				event_count_value <= {`GWEC_CNT_W{1'b0}}; // R10
			else if (count_ok)
				event_count_value <= inc_val;
			else if (cnt_clr_wr)
				event_count_value <= {`GWEC_CNT_W{1'b0}}; // R12
			// set beats clear on the same cycle
			if (match && wake_control[`GWEC_CTRL_IRQ_EN])
				wake_irq <= 1'b1; // R10
			else if (irq_clr_wr)
				wake_irq <= 1'b0; // R11
			irq_status <= (irq_status &
				~((wr && addr_hit(paddr_in, `GWEC_OFF_STAT)) ? pwdata_in[1:0] : 2'h0)) |
				{count_ok, match};
		end
	end

	// reads have no side effect on counting
	always @* begin
		next_rdata = 32'h00000000;
		case (1'b1)
		addr_hit(paddr_in, `GWEC_OFF_CTRL): next_rdata[6:0] = wake_control;
		addr_hit(paddr_in, `GWEC_OFF_SEL): next_rdata[`GWEC_PINS-1:0] = wake_source_select;
		addr_hit(paddr_in, `GWEC_OFF_POL): next_rdata[`GWEC_PINS-1:0] = wake_edge_polarity;
		addr_hit(paddr_in, `GWEC_OFF_THR): next_rdata[7:0] = event_count_threshold;
		addr_hit(paddr_in, `GWEC_OFF_CNT): next_rdata[7:0] = event_count_value; // R13
		addr_hit(paddr_in, `GWEC_OFF_STAT): next_rdata[2:0] = {wake_irq, irq_status};
		addr_hit(paddr_in, `GWEC_OFF_MASK): next_rdata[1:0] = irq_mask;
		default: next_rdata = 32'h00000000;
		endcase
	end

	// data registered in setup cycle, valid during access phase
	always @(posedge clk_in) begin
		if (sys_rst_in)
			prdata_out <= 32'h00000000;
		else if (clk_en_in && psel_in && !penable_in && !pwrite_in)
			prdata_out <= next_rdata;
	end
endmodule

// ### include/gwec_consts.vh
// gwec_consts.vh: register offsets, field positions, reset values and timing counts
// assumes: included by the wake event counter, 125 MHz clock, 32-bit apb
`ifndef GWEC_CONSTS_VH
`define GWEC_CONSTS_VH

`define GWEC_PINS 24
`define GWEC_CNT_W 8
`define GWEC_CLK_HZ 125000000
`define GWEC_TICK_MS 1
`define GWEC_TICK_CYC ((`GWEC_CLK_HZ / 1000) * `GWEC_TICK_MS)

`define GWEC_OFF_CTRL 12'h000
`define GWEC_OFF_SEL 12'h004
`define GWEC_OFF_POL 12'h008
`define GWEC_OFF_THR 12'h00c
`define GWEC_OFF_IRQ_CLR 12'h010
`define GWEC_OFF_CNT_CLR 12'h014
`define GWEC_OFF_CNT 12'h018
`define GWEC_OFF_STAT 12'h01c
`define GWEC_OFF_MASK 12'h020

`define GWEC_CTRL_DEB_LSB 0
`define GWEC_CTRL_DEB_MSB 5
`define GWEC_CTRL_IRQ_EN 6
`define GWEC_CTRL_RST 7'h00
`define GWEC_SEL_RST 24'h000000
`define GWEC_POL_RST 24'h000000
`define GWEC_THR_RST 8'h00
`define GWEC_MASK_RST 2'h0

`define GWEC_ST_MATCH 0
`define GWEC_ST_EDGE 1

`endif

// ### tb/gwec_wake_counter_assertions.sv
// checker: apb answers and wake outputs
// assumes: bound to the wake counter, one clock
`timescale 1ns/1ps
`include "gwec_consts.vh"
module gwec_chk (
	input wire clk_in,
	input wire sys_rst_in,
	input wire clk_en_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [11:0] paddr_in,
	input wire pready_out,
	input wire pslverr_out,
	input wire [31:0] prdata_out,
	input wire irq_out,
	input wire wake_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	wire acc = psel_in && penable_in && clk_en_in;
	wire wr = acc && pwrite_in;
	property p_rdy; pready_out; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready");
	property p_err; pslverr_out |-> psel_in && penable_in; endproperty
	a_err: assert property (p_err) else $error("stray error");
	property p_unm; acc && paddr_in > 12'h020 |-> pslverr_out; endproperty
	a_unm: assert property (p_unm) else $error("unmapped ok");
	property p_rst; $fell(sys_rst_in) |-> !wake_out && !irq_out && prdata_out == 0; endproperty
	a_rst: assert property (p_rst) else $error("reset value");
	property p_iclr; wr && paddr_in == `GWEC_OFF_IRQ_CLR |=> !wake_out; endproperty
	a_iclr: assert property (p_iclr) else $error("irq not cleared");
	property p_frz; !clk_en_in |=> $stable(wake_out) && $stable(irq_out); endproperty
	a_frz: assert property (p_frz) else $error("moved frozen");
	property p_wk; $rose(wake_out) |-> $past(clk_en_in); endproperty
	a_wk: assert property (p_wk) else $error("wake frozen");
	property p_cclr; wr && paddr_in == `GWEC_OFF_CNT_CLR ##[1:2] psel_in && !penable_in
		&& !pwrite_in && paddr_in == `GWEC_OFF_CNT && clk_en_in |=> prdata_out == 0; endproperty
	a_cclr: assert property (p_cclr) else $error("count kept");
endmodule

// ### tb/gwec_key_model.sv
// key model: switches on the wake pins
// assumes: bench sets levels after a clock edge
`timescale 1ns/1ps
module gwec_key_model (
	input wire clk_in,
	input wire [23:0] level_in,
	output reg [23:0] gpio_out
);
	// one cycle of settling, like a synchronised contact
	initial gpio_out = 24'h000000;
	always @(posedge clk_in) begin
		gpio_out <= level_in;
	end
endmodule

// ### tb/gwec_wake_counter_tb.sv
// bench: apb master and key levels
// assumes: debounce 0 so no millisecond wait
`timescale 1ns/1ps
`include "gwec_consts.vh"
module gwec_wake_counter_tb;
	reg clk_in = 0, sys_rst_in = 1, clk_en_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
	reg [11:0] paddr_in = 0;
	reg [31:0] pwdata_in = 0, rd;
	reg [23:0] lv = 24'h000002;
	reg er;
	wire [23:0] gpio_in;
	wire pready_out, pslverr_out, irq_out, wake_out;
	wire [31:0] prdata_out;
	integer fail_count = 0, checks_done = 0;
	always #4 clk_in = ~clk_in;
	gwec_wake_counter dut (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.clk_en_in(clk_en_in),
		.gpio_in(gpio_in),
		.psel_in(psel_in),
		.penable_in(penable_in),
		.pwrite_in(pwrite_in),
		.paddr_in(paddr_in),
		.pwdata_in(pwdata_in),
		.pready_out(pready_out),
		.pslverr_out(pslverr_out),
		.prdata_out(prdata_out),
		.irq_out(irq_out),
		.wake_out(wake_out)
	);
	gwec_key_model keys (.clk_in(clk_in), .level_in(lv), .gpio_out(gpio_in));
	task chk(input [31:0] got, input [31:0] exp);
		checks_done = checks_done + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		@(posedge clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do @(posedge clk_in); while (pready_out !== 1'b1);
		rd = prdata_out;
		er = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task rdc(input [11:0] a, input [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task pins(input [23:0] v);
		@(posedge clk_in);
		lv <= v;
		repeat (6) @(posedge clk_in);
	endtask
	task t_regs;
		rdc(`GWEC_OFF_SEL, 32'h0);
		apb(1'b0, 12'h040, 32'h0);
		chk(er, 1'b1);
		apb(1'b1, `GWEC_OFF_CTRL, 32'h3f);
		rdc(`GWEC_OFF_CTRL, 32'h3f);
	endtask
	// a write while the clock enable is low must leave the register alone
	task t_frz;
		@(posedge clk_in);
		clk_en_in <= 1'b0;
		apb(1'b1, `GWEC_OFF_CTRL, 32'h15);
		clk_en_in <= 1'b1;
		rdc(`GWEC_OFF_CTRL, 32'h3f);
	endtask
	task t_count;
		apb(1'b1, `GWEC_OFF_CTRL, 32'h40);
		apb(1'b1, `GWEC_OFF_SEL, 32'h3);
		apb(1'b1, `GWEC_OFF_POL, 32'h2);
		apb(1'b1, `GWEC_OFF_THR, 32'h3);
		apb(1'b1, `GWEC_OFF_MASK, 32'h1);
		pins(24'h3);
		rdc(`GWEC_OFF_CNT, 32'h1);
		pins(24'h1);
		rdc(`GWEC_OFF_CNT, 32'h1);
		pins(24'h0);
		pins(24'h2);
		pins(24'h0);
		rdc(`GWEC_OFF_CNT, 32'h2);
		pins(24'h6);
		rdc(`GWEC_OFF_CNT, 32'h2);
		pins(24'h7);
		rdc(`GWEC_OFF_CNT, 32'h0);
		@(negedge clk_in);
		chk(wake_out, 1'b1);
	endtask
	task t_irq;
		@(negedge clk_in);
		chk(irq_out, 1'b1);
		apb(1'b1, `GWEC_OFF_MASK, 32'h0);
		@(negedge clk_in);
		chk(irq_out, 1'b0);
		apb(1'b1, `GWEC_OFF_STAT, 32'h1);
		apb(1'b1, `GWEC_OFF_MASK, 32'h1);
		@(negedge clk_in);
		chk(irq_out, 1'b0);
		apb(1'b1, `GWEC_OFF_IRQ_CLR, 32'h0);
		@(negedge clk_in);
		chk(wake_out, 1'b0);
		pins(24'h2);
		pins(24'h3);
		rdc(`GWEC_OFF_CNT, 32'h1);
		apb(1'b1, `GWEC_OFF_CNT_CLR, 32'h0);
		rdc(`GWEC_OFF_CNT, 32'h0);
	endtask
	task complete_run;
		$display("fail_count=%0d checks_done=%0d", fail_count, checks_done);
		if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#100000;
		fail_count = fail_count + 1;
		complete_run;
	end
	initial begin
		repeat (16) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		t_regs;
		t_frz;
		t_count;
		t_irq;
		complete_run;
	end
endmodule
bind gwec_wake_counter gwec_chk chk (.*);
